// File: hdl/lsu_pkg.sv
// Shared constants and types for the load/store control block
package lsu_pkg;
  localparam int XLEN = 32;
  // Instruction fields, bit 0 = least significant
  localparam int PRIM_MSB = 31;
  localparam int PRIM_LSB = 26;
  localparam int TGT_MSB = 25;
  localparam int TGT_LSB = 21;
  localparam int BASE_MSB = 20;
  localparam int BASE_LSB = 16;
  localparam int IDX_MSB = 15;
  localparam int IDX_LSB = 11;
  localparam int XO_MSB = 10;
  localparam int XO_LSB = 1;
  localparam logic [5:0] PRIM_OP_X = 6'h1f;
  localparam logic [9:0] XO_SPACE_WORD_A_LOAD = 10'h21e;
  localparam logic [9:0] XO_SPACE_WORD_A_STORE = 10'h29e;
  localparam logic [4:0] ZERO_BASE_FIELD = 5'h00;
  // Reservation granule: address bits below this index are ignored
  localparam int GRANULE_LSB = 5;
  localparam logic [XLEN-1:0] RESET_WORD = 32'h0000_0000;

  // Operation class handed over by the issue stage for non-diagnostic work
  typedef enum logic [2:0] {
    KIND_OTHER = 3'h0,
    KIND_LOAD = 3'h1,
    KIND_STORE = 3'h2,
    KIND_IO_BARRIER = 3'h3,
    KIND_FULL_SYNC = 3'h4,
    KIND_LOAD_RESERVE = 3'h5,
    KIND_STORE_COND = 3'h6
  } op_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SPACE_WORD_A = 3'b010,
    ST_BARRIER = 3'b100
  } lsu_state_t;
endpackage

// File: hdl/resv_track.sv
// Load-reserve reservation holder with snoop cancellation
`timescale 1ns/1ps
module resv_track
  import lsu_pkg::*;
#(
  parameter int AW = XLEN,
  parameter int GLSB = GRANULE_LSB
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic set_resv,
  input wire logic [AW-1:0] set_addr,
  input wire logic clear_resv,
  input wire logic snoop_inval,
  input wire logic [AW-1:0] snoop_addr,
  output logic resv_valid_q
);
  logic [AW-1:GLSB] granule_q;
  logic snoop_hit;

  // Only a block-invalidate is presented here; a remote flush never reaches this port
  assign snoop_hit = snoop_inval && resv_valid_q && (snoop_addr[AW-1:GLSB] == granule_q);

  // A fresh reservation wins over a same-cycle cancel of the old one
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      resv_valid_q <= 1'b0;
    end else if (set_resv) begin
      resv_valid_q <= 1'b1;
    end else if (clear_resv || snoop_hit) begin
      resv_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      granule_q <= '0;
    end else if (set_resv) begin
      granule_q <= set_addr[AW-1:GLSB];
    end
  end

  a_snoop_kills_resv: assert property (@(posedge ref_clk) disable iff (!reset_n)
    snoop_hit && !set_resv |=> !resv_valid_q)
    else $error("reservation survived a matching block-invalidate");
endmodule

// File: hdl/lsu_ctrl.sv
// Load/store control: diagnostic space access, storage barriers, atomics
//
// Function
// - Diagnostic load adds base (or zero for field 0) to index and loads that word.
// - Diagnostic store forms the same address and writes the source value there.
// - Diagnostic ops need the enable bit set and supervisor state, else illegal trap.
// - An undefined diagnostic address may end in a data storage trap instead.
// - Diagnostic ops never trap on alignment; low address bits pass through.
// - Ordering is weak; stores in one doubleword may merge outside this block.
// - The I/O barrier waits for an empty store queue and the L2 broadcast report.
// - Loads and stores after the I/O barrier are held until it completes.
// - The I/O barrier orders storage and translation work as one set.
// - The full sync waits for an empty store queue and an idle L2.
// - No instruction cache coherence is kept; software manages it.
// - Atomics act the same whatever the write-through attribute.
// - Store-conditional with a reservation stores even to a different address.
// - A remote block-invalidate to the granule cancels the reservation, a flush does not.
`timescale 1ns/1ps
module lsu_ctrl
  import lsu_pkg::*;
#(
  parameter int AW = XLEN,
  parameter int DW = XLEN
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire op_kind_t issue_kind,
  input wire logic [AW-1:0] base_val,
  input wire logic [AW-1:0] index_val,
  input wire logic [DW-1:0] source_val,
  input wire logic space_word_a_enable_bit,
  input wire logic problem_state_bit,
  input wire logic space_word_a_ack,
  input wire logic space_word_a_undef,
  input wire logic [DW-1:0] space_word_a_rdata,
  input wire logic store_queue_empty,
  input wire logic l2_tlb_bcast_done,
  input wire logic l2_idle,
  input wire logic snoop_inval,
  input wire logic [AW-1:0] snoop_addr,
  output logic issue_ready_q,
  output logic illegal_instr_q,
  output logic dsi_q,
  output logic space_word_a_req_q,
  output logic space_word_a_we_q,
  output logic [AW-1:0] space_word_a_addr_q,
  output logic [DW-1:0] space_word_a_wdata_q,
  output logic wb_valid_q,
  output logic [4:0] wb_reg_q,
  output logic [DW-1:0] wb_data_q,
  output logic mem_req_q,
  output logic mem_we_q,
  output logic [AW-1:0] mem_addr_q,
  output logic [DW-1:0] mem_wdata_q,
  output logic barrier_done_q,
  output logic stcx_done_q,
  output logic stcx_pass_q,
  output logic resv_valid_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  function automatic logic [AW-1:0] ea_calc(input logic [4:0] base_field,
                                            input logic [AW-1:0] base,
                                            input logic [AW-1:0] index);
    logic [AW-1:0] b;
    b = (base_field == ZERO_BASE_FIELD) ? '0 : base;
    return b + index;
  endfunction

  function automatic logic is_space_word_a(input logic [31:0] instr, input logic [9:0] xo);
    return (instr[PRIM_MSB:PRIM_LSB] == PRIM_OP_X) && (instr[XO_MSB:XO_LSB] == xo);
  endfunction

  lsu_state_t state_q, state_d;
  logic take, space_word_a_ld, space_word_a_st, space_word_a_hit, space_word_a_ok, bar_req, bar_met, bar_sync_q;
  logic is_mem, stcx_take, lwarx_take;
  logic [AW-1:0] ea;

  assign take = issue_valid && issue_ready_q;
  assign ea = ea_calc(issue_instr[BASE_MSB:BASE_LSB], base_val, index_val);
  assign space_word_a_ld = is_space_word_a(issue_instr, XO_SPACE_WORD_A_LOAD);
  assign space_word_a_st = is_space_word_a(issue_instr, XO_SPACE_WORD_A_STORE);
  assign space_word_a_hit = take && (space_word_a_ld || space_word_a_st);
  assign space_word_a_ok = space_word_a_enable_bit && !problem_state_bit;
  assign bar_req = take && !(space_word_a_ld || space_word_a_st)
                   && (issue_kind == KIND_IO_BARRIER || issue_kind == KIND_FULL_SYNC);
  // One barrier state orders storage and translation work together
  assign bar_met = store_queue_empty
                   && (bar_sync_q ? l2_idle : l2_tlb_bcast_done);
  assign lwarx_take = take && !(space_word_a_ld || space_word_a_st) && issue_kind == KIND_LOAD_RESERVE;
  assign stcx_take = take && !(space_word_a_ld || space_word_a_st) && issue_kind == KIND_STORE_COND;
  // Reservation test ignores the address and any write-through attribute
  assign is_mem = take && !(space_word_a_ld || space_word_a_st)
                  && (issue_kind == KIND_LOAD || issue_kind == KIND_STORE || lwarx_take
                      || (stcx_take && resv_valid_q));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (space_word_a_hit && space_word_a_ok) begin
          state_d = ST_SPACE_WORD_A;
        end else if (bar_req) begin
          state_d = ST_BARRIER;
        end
      end
      ST_SPACE_WORD_A: begin
        if (space_word_a_ack) begin
          state_d = ST_IDLE;
        end
      end
      ST_BARRIER: begin
        if (bar_met) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Issue is refused while a diagnostic access or barrier is open
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      issue_ready_q <= 1'b0;
    end else begin
      issue_ready_q <= (state_d == ST_IDLE);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      bar_sync_q <= 1'b0;
    end else if (bar_req) begin
      bar_sync_q <= (issue_kind == KIND_FULL_SYNC);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      barrier_done_q <= 1'b0;
    end else begin
      barrier_done_q <= (state_q == ST_BARRIER) && bar_met;
    end
  end

  // Illegal check gates the request, so a trapped op touches nothing
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      illegal_instr_q <= 1'b0;
    end else begin
      illegal_instr_q <= space_word_a_hit && !space_word_a_ok;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      space_word_a_req_q <= 1'b0;
    end else begin
      space_word_a_req_q <= (state_d == ST_SPACE_WORD_A);
    end
  end

  // Full address goes out unaligned as is; no alignment trap exists here
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      space_word_a_we_q <= 1'b0;
      space_word_a_addr_q <= RESET_WORD;
      space_word_a_wdata_q <= RESET_WORD;
      wb_reg_q <= ZERO_BASE_FIELD;
    end else if (space_word_a_hit && space_word_a_ok) begin
      space_word_a_we_q <= space_word_a_st;
      space_word_a_addr_q <= ea;
      space_word_a_wdata_q <= source_val;
      wb_reg_q <= issue_instr[TGT_MSB:TGT_LSB];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wb_valid_q <= 1'b0;
      wb_data_q <= RESET_WORD;
      dsi_q <= 1'b0;
    end else begin
      wb_valid_q <= space_word_a_req_q && space_word_a_ack && !space_word_a_undef && !space_word_a_we_q;
      dsi_q <= space_word_a_req_q && space_word_a_ack && space_word_a_undef;
      if (space_word_a_req_q && space_word_a_ack && !space_word_a_undef && !space_word_a_we_q) begin
        wb_data_q <= space_word_a_rdata;
      end
    end
  end

  // Stores leave unordered; merging within a doubleword happens in the store queue
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= RESET_WORD;
      mem_wdata_q <= RESET_WORD;
    end else begin
      mem_req_q <= is_mem;
      if (is_mem) begin
        mem_we_q <= (issue_kind == KIND_STORE) || stcx_take;
        mem_addr_q <= ea;
        mem_wdata_q <= source_val;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stcx_done_q <= 1'b0;
      stcx_pass_q <= 1'b0;
    end else begin
      stcx_done_q <= stcx_take;
      stcx_pass_q <= stcx_take && resv_valid_q;
    end
  end

  // Instruction cache snoops nothing from these stores; software flushes it
  resv_track #(.AW(AW), .GLSB(GRANULE_LSB)) u_resv_track (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .set_resv(lwarx_take),
    .set_addr(ea),
    .clear_resv(stcx_take),
    .snoop_inval(snoop_inval),
    .snoop_addr(snoop_addr),
    .resv_valid_q(resv_valid_q)
  );

  a_illegal_no_access: assert property (space_word_a_hit && !space_word_a_ok
    |=> illegal_instr_q && !space_word_a_req_q && !wb_valid_q)
    else $error("illegal diagnostic op still accessed the space");
  a_legal_space_word_a_addr: assert property (space_word_a_hit && space_word_a_ok
    |=> space_word_a_req_q && !illegal_instr_q && space_word_a_addr_q == $past(ea))
    else $error("legal diagnostic op issued with wrong address");
  a_space_word_a_store_data: assert property (space_word_a_hit && space_word_a_ok && space_word_a_st
    |=> space_word_a_we_q && space_word_a_wdata_q == $past(source_val))
    else $error("diagnostic store data not captured");
  a_priv_gate: assert property (space_word_a_hit && problem_state_bit |=> illegal_instr_q)
    else $error("user-state diagnostic op not trapped");
  a_undef_dsi: assert property (space_word_a_req_q && space_word_a_ack && space_word_a_undef
    |=> dsi_q && !wb_valid_q)
    else $error("undefined diagnostic address did not trap");
  a_unaligned_ok: assert property (space_word_a_hit && space_word_a_ok && ea[1:0] != 2'b00
    |=> space_word_a_req_q && space_word_a_addr_q[1:0] == $past(ea[1:0]))
    else $error("unaligned diagnostic op was disturbed");
  a_barrier_sq: assert property (state_q == ST_BARRIER && !store_queue_empty
    |=> !barrier_done_q)
    else $error("barrier finished with stores queued");
  a_barrier_holds: assert property (state_q == ST_BARRIER
    |-> !issue_ready_q ##1 !mem_req_q)
    else $error("access issued during barrier");
  a_io_bar_bcast: assert property (state_q == ST_BARRIER && !bar_sync_q
    && !l2_tlb_bcast_done |=> !barrier_done_q)
    else $error("I/O barrier finished before broadcast report");
  a_sync_l2_idle: assert property (state_q == ST_BARRIER && bar_sync_q && !l2_idle
    |=> !barrier_done_q)
    else $error("sync finished with L2 busy");
  // Reservation drop is checked one cycle on, before a following load-reserve can set it again
  a_stcx_stores: assert property (stcx_take && resv_valid_q
    |=> mem_req_q && mem_we_q && stcx_pass_q && !resv_valid_q)
    else $error("store-conditional with reservation did not store");

  c_space_word_a_load: cover property (space_word_a_hit && space_word_a_ok && space_word_a_ld ##[1:20] wb_valid_q);
  c_sync_done: cover property (bar_req && issue_kind == KIND_FULL_SYNC ##[1:50] barrier_done_q);
  c_stcx_fail: cover property (stcx_take && !resv_valid_q);
  c_snoop_kill: cover property (resv_valid_q && snoop_inval ##1 !resv_valid_q);
endmodule

// File: sim/space_word_a_space_model.sv
// Diagnostic address space model answering the load/store block
`timescale 1ns/1ps
module space_word_a_space_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [3:0] lat,
  input wire logic space_word_a_req_q,
  input wire logic space_word_a_we_q,
  input wire logic [31:0] space_word_a_addr_q,
  input wire logic [31:0] space_word_a_wdata_q,
  output logic space_word_a_ack,
  output logic space_word_a_undef,
  output logic [31:0] space_word_a_rdata
);
  logic [31:0] mem [16];
  logic [3:0] cnt;
  logic undef_hit;
  assign undef_hit = space_word_a_addr_q[31:28] == 4'hf;
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    cnt = 4'h0;
    space_word_a_ack = 1'b0;
    space_word_a_undef = 1'b0;
    space_word_a_rdata = 32'h0;
  end
  always @(posedge ref_clk) begin
    // Read data outside an answer toggles so stale words never look valid
    space_word_a_rdata <= ~space_word_a_rdata;
    space_word_a_undef <= 1'b0;
    if (!reset_n || space_word_a_ack) begin
      space_word_a_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (space_word_a_req_q && cnt == lat) begin
      space_word_a_ack <= 1'b1;
      space_word_a_undef <= undef_hit;
      space_word_a_rdata <= mem[space_word_a_addr_q[5:2]];
      if (space_word_a_we_q && !undef_hit) mem[space_word_a_addr_q[5:2]] <= space_word_a_wdata_q;
    end else if (space_word_a_req_q) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// File: sim/testbench.sv
// Self-checking bench for the load/store control block
`timescale 1ns/1ps
module testbench;
  import lsu_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic issue_valid = 1'b0;
  logic [31:0] issue_instr = 32'h0;
  op_kind_t issue_kind = KIND_OTHER;
  logic [31:0] base_val = 32'h0, index_val = 32'h0, source_val = 32'h0;
  logic space_word_a_enable_bit = 1'b0, problem_state_bit = 1'b0, snoop_inval = 1'b0;
  logic store_queue_empty = 1'b1, l2_tlb_bcast_done = 1'b1, l2_idle = 1'b1;
  logic [31:0] snoop_addr = 32'h0, space_word_a_rdata, space_word_a_addr_q, space_word_a_wdata_q;
  logic [31:0] wb_data_q, mem_addr_q, mem_wdata_q;
  logic [3:0] lat = 4'h0;
  logic [4:0] wb_reg_q;
  logic space_word_a_ack, space_word_a_undef, issue_ready_q, illegal_instr_q, dsi_q, space_word_a_req_q;
  logic space_word_a_we_q, wb_valid_q, mem_req_q, mem_we_q, barrier_done_q;
  logic stcx_done_q, stcx_pass_q, resv_valid_q, req_prev = 1'b0, hold_done = 1'b0;
  logic [39:0] exp_q[$];
  logic [31:0] shadow [16];
  logic [31:0] b, x, d;
  integer seed = 32'h5f58;
  int miscompares = 0;
  int cmp_count = 0;

  lsu_ctrl u_lsu_ctrl (.ref_clk, .reset_n, .issue_valid, .issue_instr, .issue_kind,
    .base_val, .index_val, .source_val, .space_word_a_enable_bit, .problem_state_bit,
    .space_word_a_ack, .space_word_a_undef, .space_word_a_rdata, .store_queue_empty, .l2_tlb_bcast_done,
    .l2_idle, .snoop_inval, .snoop_addr, .issue_ready_q, .illegal_instr_q, .dsi_q,
    .space_word_a_req_q, .space_word_a_we_q, .space_word_a_addr_q, .space_word_a_wdata_q, .wb_valid_q, .wb_reg_q,
    .wb_data_q, .mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q, .barrier_done_q,
    .stcx_done_q, .stcx_pass_q, .resv_valid_q);
  space_word_a_space_model u_space_word_a_space_model (.ref_clk, .reset_n, .lat, .space_word_a_req_q,
    .space_word_a_we_q, .space_word_a_addr_q, .space_word_a_wdata_q, .space_word_a_ack, .space_word_a_undef, .space_word_a_rdata);

  always #5 ref_clk = ~ref_clk;

  task end_of_test;
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task note(input logic [7:0] t, input logic [31:0] v);
    exp_q.push_back({t, v});
  endtask

  task take(input logic [7:0] t, input logic [31:0] v);
    logic [39:0] e;
    cmp_count++;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 40'h0;
    if (e !== {t, v}) begin
      $display("CHECK FAILED event expected %h seen %h", e, {t, v});
      miscompares++;
    end
  endtask

  // Results are compared in a fixed order within a cycle
  always @(posedge ref_clk) begin
    #2;
    if (space_word_a_req_q !== 1'b0 && !req_prev) begin
      take(8'h6, space_word_a_addr_q);
      if (space_word_a_we_q !== 1'b0) take(8'h8, space_word_a_wdata_q);
    end
    req_prev = space_word_a_req_q;
    if (mem_req_q !== 1'b0) begin
      take(mem_we_q ? 8'h9 : 8'h7, mem_addr_q);
      if (mem_we_q !== 1'b0) take(8'ha, mem_wdata_q);
    end
    if (wb_valid_q !== 1'b0) take({3'h1, wb_reg_q}, wb_data_q);
    if (illegal_instr_q !== 1'b0) take(8'h2, 32'h0);
    if (dsi_q !== 1'b0) take(8'h3, 32'h0);
    if (barrier_done_q !== 1'b0) take(8'h4, {31'h0, hold_done});
    if (stcx_done_q !== 1'b0) take(8'h5, {31'h0, stcx_pass_q});
  end

  // Valid stays up between requests so back-to-back issue is exercised
  task issue(input logic [31:0] ins, input op_kind_t k, input logic [31:0] bb, xx, s);
    logic rdy;
    int n;
    issue_instr = ins;
    issue_kind = k;
    base_val = bb;
    index_val = xx;
    source_val = s;
    issue_valid = 1'b1;
    for (n = 0; n < 200; n++) begin
      rdy = issue_ready_q;
      @(posedge ref_clk);
      #1;
      if (rdy === 1'b1) break;
    end
    if (n == 200) begin
      miscompares++;
      end_of_test;
    end
  endtask

  task idle(input int n);
    issue_valid = 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task mop(input op_kind_t k, input logic [31:0] a, s);
    issue({PRIM_OP_X, 15'h0864, 10'h096, 1'b0}, k, a, 32'h0, s);
  endtask

  task space_word_a(input logic we, de, pr, bz, input logic [31:0] bb, xx);
    logic [31:0] ea, s;
    logic [4:0] r;
    ea = (bz ? 32'h0 : bb) + xx;
    s = $random(seed);
    r = 5'($random(seed));
    space_word_a_enable_bit = de;
    problem_state_bit = pr;
    if (!de || pr) note(8'h2, 32'h0);
    else begin
      note(8'h6, ea);
      if (we) note(8'h8, s);
      if (ea[31:28] == 4'hf) note(8'h3, 32'h0);
      else if (we) shadow[ea[5:2]] = s;
      else note({3'h1, r}, shadow[ea[5:2]]);
    end
    issue({PRIM_OP_X, r, bz ? ZERO_BASE_FIELD : 5'h03, 5'h04,
      we ? XO_SPACE_WORD_A_STORE : XO_SPACE_WORD_A_LOAD, 1'b0}, KIND_OTHER, bb, xx, s);
  endtask

  task barrier(input op_kind_t k);
    store_queue_empty = 1'b0;
    l2_idle = (k == KIND_IO_BARRIER);
    l2_tlb_bcast_done = (k != KIND_IO_BARRIER);
    hold_done = 1'b1;
    d = $random(seed);
    note(8'h4, 32'h0);
    note((k == KIND_IO_BARRIER) ? 8'h7 : 8'h9, 32'h100);
    if (k != KIND_IO_BARRIER) note(8'ha, d);
    // Release timing starts only once the barrier is taken, so an early finish shows
    issue({PRIM_OP_X, 15'h0, 10'h356, 1'b0}, k, 32'h0, 32'h0, 32'h0);
    fork
      mop((k == KIND_IO_BARRIER) ? KIND_LOAD : KIND_STORE, 32'h100, d);
      begin
        repeat (5) @(posedge ref_clk);
        #1;
        store_queue_empty = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1;
        hold_done = 1'b0;
        l2_idle = 1'b1;
        l2_tlb_bcast_done = 1'b1;
      end
    join
  endtask

  task rsv(input logic [31:0] sa, input logic p);
    d = $random(seed);
    note(8'h7, 32'h240);
    mop(KIND_LOAD_RESERVE, 32'h240, d);
    idle(1);
    snoop_inval = 1'b1;
    snoop_addr = sa;
    @(posedge ref_clk);
    #1;
    snoop_inval = 1'b0;
    cmp_count++;
    if (resv_valid_q !== p) begin
      $display("CHECK FAILED resv_valid_q expected %b seen %b", p, resv_valid_q);
      miscompares++;
    end
    if (p) begin
      note(8'h9, 32'h9a0);
      note(8'ha, d);
    end
    note(8'h5, {31'h0, p});
    mop(KIND_STORE_COND, 32'h9a0, d);
  endtask

  initial begin
    foreach (shadow[i]) shadow[i] = 32'h0;
    repeat (16) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    idle(2);
    for (int i = 0; i < 8; i++) begin
      lat = 4'(i);
      b = $random(seed) & 32'h0fff_ffff;
      x = ($random(seed) & 32'h00ff_fffc) | i[2:1];
      space_word_a(1'b1, 1'b1, 1'b0, i[0], b, x);
      space_word_a(1'b0, 1'b1, 1'b0, i[0], b, x);
    end
    for (int j = 0; j < 6; j++) space_word_a(j[0], j[2:1] == 1, j[2:1] != 0, 1'b0, b, x);
    space_word_a(1'b0, 1'b1, 1'b0, 1'b0, b, x);
    space_word_a(1'b0, 1'b1, 1'b0, 1'b0, 32'hf000_0000, 32'h10);
    space_word_a(1'b1, 1'b1, 1'b0, 1'b0, 32'hf000_0000, 32'h20);
    barrier(KIND_IO_BARRIER);
    barrier(KIND_FULL_SYNC);
    rsv(32'h260, 1'b1);
    note(8'h5, 32'h0);
    mop(KIND_STORE_COND, 32'h240, d);
    rsv(32'h25c, 1'b0);
    idle(20);
    if (exp_q.size() != 0) begin
      $display("CHECK FAILED pending results expected 0 seen %0d", exp_q.size());
      miscompares++;
    end
    end_of_test;
  end
endmodule
